// ---- sink_blink_pkg.sv ----
package sink_blink_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ADDR_SINK_FADE_LAW         = 8'h1A;
  localparam logic [7:0] ADDR_SINK_ENABLE_CONTROL   = 8'h1B;
  localparam logic [7:0] ADDR_SINK_BLINK_TIME_UPPER = 8'h1C;
  localparam logic [7:0] ADDR_SINK_BLINK_TIME_LOWER = 8'h1D;

  localparam logic [7:0] RESET_SINK_FADE_LAW         = 8'h00;
  localparam logic [7:0] RESET_SINK_ENABLE_CONTROL   = 8'h00;
  localparam logic [7:0] RESET_SINK_BLINK_TIME_UPPER = 8'h00;
  localparam logic [7:0] RESET_SINK_BLINK_TIME_LOWER = 8'h00;

  localparam logic [7:0] MASK_FADE_LAW = 8'h03;
  localparam logic [7:0] MASK_ENABLE   = 8'h7F;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int NUM_SINKS       = 7;
  localparam int ON_TIME_LSB     = 6;
  localparam int OFF_FIELD_WIDTH = 2;

  // ==========================================================================
  // Fade law codes and decoded profiles
  // ==========================================================================
  localparam logic [1:0] LAW_LINEAR_A = 2'h0;
  localparam logic [1:0] LAW_LINEAR_B = 2'h1;
  localparam logic [1:0] LAW_CUBIC_10 = 2'h2;
  localparam logic [1:0] LAW_CUBIC_11 = 2'h3;

  localparam logic [1:0] PROFILE_LINEAR  = 2'h0;
  localparam logic [1:0] PROFILE_CUBIC_A = 2'h1;
  localparam logic [1:0] PROFILE_CUBIC_B = 2'h2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLOCK_HZ     = 40_000_000;
  localparam int TICK_MS      = 200;
  localparam int TICK_CYCLES_DEFAULT = (CLOCK_HZ / 1000) * TICK_MS;

  localparam int ON_TIME_00_MS  = 200;
  localparam int ON_TIME_01_MS  = 600;
  localparam int ON_TIME_10_MS  = 800;
  localparam int ON_TIME_11_MS  = 1200;
  localparam int OFF_TIME_01_MS = 600;
  localparam int OFF_TIME_10_MS = 1200;
  localparam int OFF_TIME_11_MS = 1800;

  localparam logic [1:0] OFF_DISABLED = 2'h0;

  localparam int TICK_COUNT_WIDTH = 4;

  typedef enum logic {PH_ON, PH_OFF} phase_e;

endpackage

// ---- led_sink_blink_fade_control.sv ----
// Overview of operation
// - Law codes 00 and 01 select linear steps.
// - Law code 10 selects first cubic profile.
// - Law code 11 selects second cubic profile.
// - Control bits 0..6 enable sinks one..seven.
// - On-time code maps to 0.2/0.6/0.8/1.2 s.
// - Blinking sink stays on for on-time first.
// - Upper time register holds sinks seven..five off-times.
// - Off-time code maps disabled/0.6/1.2/1.8 s.
// - Disabled off-time keeps enabled sink steadily on.
// - Nonzero off-time alternates off and on periods.
// - Lower time register holds sinks four..one off-times.
// - Sinks enabled together start blinking together.
`timescale 1ns/1ps
module led_sink_blink_fade_control
  import sink_blink_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  output logic      [7:0] RDATA,
  output logic      [6:0] SINK_ON,
  output logic      [1:0] FADE_PROFILE
);

  // ==========================================================================
  // Interval decoding
  // ==========================================================================
  function automatic logic [TICK_COUNT_WIDTH-1:0] on_ticks(input logic [1:0] code);
    case (code)
      2'h0:    on_ticks = TICK_COUNT_WIDTH'(ON_TIME_00_MS / TICK_MS);
      2'h1:    on_ticks = TICK_COUNT_WIDTH'(ON_TIME_01_MS / TICK_MS);
      2'h2:    on_ticks = TICK_COUNT_WIDTH'(ON_TIME_10_MS / TICK_MS);
      default: on_ticks = TICK_COUNT_WIDTH'(ON_TIME_11_MS / TICK_MS);
    endcase
  endfunction

  function automatic logic [TICK_COUNT_WIDTH-1:0] off_ticks(input logic [1:0] code);
    case (code)
      2'h1:    off_ticks = TICK_COUNT_WIDTH'(OFF_TIME_01_MS / TICK_MS);
      2'h2:    off_ticks = TICK_COUNT_WIDTH'(OFF_TIME_10_MS / TICK_MS);
      2'h3:    off_ticks = TICK_COUNT_WIDTH'(OFF_TIME_11_MS / TICK_MS);
      default: off_ticks = '0;
    endcase
  endfunction

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [7:0] sink_fade_law;
  logic [7:0] sink_enable_control;
  logic [7:0] sink_blink_time_upper;
  logic [7:0] sink_blink_time_lower;

  wire wr_law   = WR && (ADDR == ADDR_SINK_FADE_LAW);
  wire wr_ctrl  = WR && (ADDR == ADDR_SINK_ENABLE_CONTROL);
  wire wr_upper = WR && (ADDR == ADDR_SINK_BLINK_TIME_UPPER);
  wire wr_lower = WR && (ADDR == ADDR_SINK_BLINK_TIME_LOWER);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      sink_fade_law         <= RESET_SINK_FADE_LAW;
      sink_enable_control   <= RESET_SINK_ENABLE_CONTROL;
      sink_blink_time_upper <= RESET_SINK_BLINK_TIME_UPPER;
      sink_blink_time_lower <= RESET_SINK_BLINK_TIME_LOWER;
    end else begin
      if (wr_law) begin
        sink_fade_law <= WDATA & MASK_FADE_LAW;
      end
      if (wr_ctrl) begin
        sink_enable_control <= WDATA & MASK_ENABLE;
      end
      if (wr_upper) begin
        sink_blink_time_upper <= WDATA;
      end
      if (wr_lower) begin
        sink_blink_time_lower <= WDATA;
      end
    end
  end

  // Read data is registered so the bus sees a stable byte one cycle after the address.
  logic [7:0] next_rdata;

  always_comb begin
    case (ADDR)
      ADDR_SINK_FADE_LAW:         next_rdata = sink_fade_law;
      ADDR_SINK_ENABLE_CONTROL:   next_rdata = sink_enable_control;
      ADDR_SINK_BLINK_TIME_UPPER: next_rdata = sink_blink_time_upper;
      ADDR_SINK_BLINK_TIME_LOWER: next_rdata = sink_blink_time_lower;
      default:                    next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ==========================================================================
  // Field decoding
  // ==========================================================================
  // Every field has its own name, so the timer loop below reads register fields only through packed vectors.
  wire [1:0]                 fade_law_select     = sink_fade_law[1:0];
  wire                       sink_one_enable     = sink_enable_control[0];
  wire                       sink_two_enable     = sink_enable_control[1];
  wire                       sink_three_enable   = sink_enable_control[2];
  wire                       sink_four_enable    = sink_enable_control[3];
  wire                       sink_five_enable    = sink_enable_control[4];
  wire                       sink_six_enable     = sink_enable_control[5];
  wire                       sink_seven_enable   = sink_enable_control[6];
  wire [OFF_FIELD_WIDTH-1:0] sink_one_off_time   = sink_blink_time_lower[1:0];
  wire [OFF_FIELD_WIDTH-1:0] sink_two_off_time   = sink_blink_time_lower[3:2];
  wire [OFF_FIELD_WIDTH-1:0] sink_three_off_time = sink_blink_time_lower[5:4];
  wire [OFF_FIELD_WIDTH-1:0] sink_four_off_time  = sink_blink_time_lower[7:6];
  wire [OFF_FIELD_WIDTH-1:0] sink_five_off_time  = sink_blink_time_upper[1:0];
  wire [OFF_FIELD_WIDTH-1:0] sink_six_off_time   = sink_blink_time_upper[3:2];
  wire [OFF_FIELD_WIDTH-1:0] sink_seven_off_time = sink_blink_time_upper[5:4];
  wire [1:0]                 shared_on_time      = sink_blink_time_upper[ON_TIME_LSB +: 2];

  // ==========================================================================
  // Fade profile selection
  // ==========================================================================
  logic [1:0] next_profile;

  always_comb begin
    case (fade_law_select)
      LAW_LINEAR_A: next_profile = PROFILE_LINEAR;
      LAW_LINEAR_B: next_profile = PROFILE_LINEAR;
      LAW_CUBIC_10: next_profile = PROFILE_CUBIC_A;
      default:      next_profile = PROFILE_CUBIC_B;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      FADE_PROFILE <= PROFILE_LINEAR;
    end else begin
      FADE_PROFILE <= next_profile;
    end
  end

  // ==========================================================================
  // Shared time base
  // ==========================================================================
  // A single prescaler keeps every sink on the same grid, so sinks enabled in one
  // write stay in lock step while their off-times match; the price is that a sink's first interval
  // may end up to one tick early, since the write does not restart the prescaler.
  logic [31:0] prescale;
  wire         tick = (prescale == 32'(TICK_CYCLES - 1));

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      prescale <= '0;
    end else if (tick) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 32'h1;
    end
  end

  // ==========================================================================
  // Per-sink blink timers
  // ==========================================================================
  wire [13:0] off_fields = {sink_seven_off_time, sink_six_off_time, sink_five_off_time, sink_four_off_time,
                            sink_three_off_time, sink_two_off_time, sink_one_off_time};
  wire [1:0]  on_code    = shared_on_time;
  wire [TICK_COUNT_WIDTH-1:0] on_limit = on_ticks(on_code);

  phase_e                        phase      [NUM_SINKS];
  logic   [TICK_COUNT_WIDTH-1:0] tick_count [NUM_SINKS];
  logic   [NUM_SINKS-1:0]        enabled_q;

  wire [NUM_SINKS-1:0] enable = {sink_seven_enable, sink_six_enable, sink_five_enable, sink_four_enable,
                                 sink_three_enable, sink_two_enable, sink_one_enable};
  wire [NUM_SINKS-1:0] rising = enable & ~enabled_q;

  // Interval ends are decoded apart from the timer flops, so the flops only pick a branch.
  logic [NUM_SINKS-1:0] blinking;
  logic [NUM_SINKS-1:0] on_done;
  logic [NUM_SINKS-1:0] off_done;

  always_comb begin
    for (int i = 0; i < NUM_SINKS; i++) begin
      blinking[i] = (off_fields[i*OFF_FIELD_WIDTH +: OFF_FIELD_WIDTH] != OFF_DISABLED);
      on_done[i]  = ((tick_count[i] + TICK_COUNT_WIDTH'(1)) >= on_limit);
      off_done[i] = ((tick_count[i] + TICK_COUNT_WIDTH'(1)) >=
                     off_ticks(off_fields[i*OFF_FIELD_WIDTH +: OFF_FIELD_WIDTH]));
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      enabled_q <= '0;
      SINK_ON   <= '0;
      for (int i = 0; i < NUM_SINKS; i++) begin
        phase[i]      <= PH_ON;
        tick_count[i] <= '0;
      end
    end else begin
      enabled_q <= enable;
      for (int i = 0; i < NUM_SINKS; i++) begin
        if (!enable[i]) begin
          phase[i]      <= PH_ON;
          tick_count[i] <= '0;
          SINK_ON[i]    <= 1'b0;
        end else if (rising[i]) begin
          phase[i]      <= PH_ON;
          tick_count[i] <= '0;
          SINK_ON[i]    <= 1'b1;
        end else if (!blinking[i]) begin
          phase[i]      <= PH_ON;
          tick_count[i] <= '0;
          SINK_ON[i]    <= 1'b1;
        end else if (tick) begin
          case (phase[i])
            PH_ON: begin
              if (on_done[i]) begin
                phase[i]      <= PH_OFF;
                tick_count[i] <= '0;
                SINK_ON[i]    <= 1'b0;
              end else begin
                tick_count[i] <= tick_count[i] + 4'h1;
                SINK_ON[i]    <= 1'b1;
              end
            end
            PH_OFF: begin
              if (off_done[i]) begin
                phase[i]      <= PH_ON;
                tick_count[i] <= '0;
                SINK_ON[i]    <= 1'b1;
              end else begin
                tick_count[i] <= tick_count[i] + 4'h1;
                SINK_ON[i]    <= 1'b0;
              end
            end
            default: begin
              phase[i]      <= PH_ON;
              tick_count[i] <= '0;
              SINK_ON[i]    <= 1'b0;
            end
          endcase
        end else begin
          SINK_ON[i] <= (phase[i] == PH_ON);
        end
      end
    end
  end

endmodule

// ---- sink_blink_chk.sv ----
`timescale 1ns/1ps
// ========================================
// Port checker
// ========================================
module sink_blink_chk
  import sink_blink_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic [7:0] RDATA,
  input wire logic [6:0] SINK_ON,
  input wire logic [1:0] FADE_PROFILE
);
  logic [6:0]  en;
  logic [13:0] offs;
  logic [6:0]  steady;
  logic        law_wr;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  assign law_wr = WR && ADDR == ADDR_SINK_FADE_LAW;
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      steady[i] = en[i] && offs[2*i +: 2] == OFF_DISABLED;
    end
  end
  // Shadow copies let the checks judge outputs without peeking inside.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      en   <= 7'h00;
      offs <= 14'h0000;
    end else if (WR && ADDR == ADDR_SINK_ENABLE_CONTROL) begin
      en <= WDATA[6:0];
    end else if (WR && ADDR == ADDR_SINK_BLINK_TIME_UPPER) begin
      offs[13:8] <= WDATA[5:0];
    end else if (WR && ADDR == ADDR_SINK_BLINK_TIME_LOWER) begin
      offs[7:0] <= WDATA;
    end
  end
  a_law_linear: assert property (law_wr && !WDATA[1] |-> ##[1:2] FADE_PROFILE == PROFILE_LINEAR)
    else $error("fade profile not linear");
  a_law_cubic_a: assert property (law_wr && WDATA[1:0] == LAW_CUBIC_10 |-> ##[1:2] FADE_PROFILE == PROFILE_CUBIC_A)
    else $error("fade profile not cubic a");
  a_law_cubic_b: assert property (law_wr && WDATA[1:0] == LAW_CUBIC_11 |-> ##[1:2] FADE_PROFILE == PROFILE_CUBIC_B)
    else $error("fade profile not cubic b");
  a_read_law: assert property (ADDR == ADDR_SINK_FADE_LAW |=> RDATA[7:2] == 6'h00)
    else $error("reserved law bits read nonzero");
  a_read_enable: assert property (ADDR == ADDR_SINK_ENABLE_CONTROL |=> RDATA == {1'b0, $past(en)})
    else $error("enable register readback wrong");
  a_sink_gated: assert property ((SINK_ON & ~$past(en)) == 7'h00)
    else $error("disabled sink conducting");
  a_steady_on: assert property ((steady & $past(steady) & ~SINK_ON) == 7'h00)
    else $error("steady sink not on");
  a_first_on: assert property ($rose(en[4]) |=> SINK_ON[4])
    else $error("blink did not start on");
  cover property (law_wr && WDATA[1:0] == LAW_CUBIC_11);
  cover property ($fell(SINK_ON[4]) && en[4]);
  cover property (steady == 7'h7F);
endmodule

bind led_sink_blink_fade_control sink_blink_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.CLOCK(CLOCK), .RST(RST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RDATA(RDATA), .SINK_ON(SINK_ON), .FADE_PROFILE(FADE_PROFILE));

// ---- sink_led_load.sv ----
`timescale 1ns/1ps
// ========================================
// LED load
// ========================================
module sink_led_load (
  input  wire logic CLOCK,
  input  wire logic lit,
  output int        last_on,
  output int        last_off
);
  int   run;
  logic prev;
  // Each run is reported when it ends, including the first on run, which may be cut short.
  always @(posedge CLOCK) begin
    if (lit !== prev) begin
      if (prev === 1'b1) last_on = run;
      else last_off = run;
      run = 1;
    end else begin
      run++;
    end
    prev = lit;
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
// ========================================
// Bench
// ========================================
module tb_top;
  import sink_blink_pkg::*;
  localparam int TK = 4;
  logic       CLOCK = 0;
  logic       RST   = 1;
  logic       WR    = 0;
  logic [7:0] ADDR  = 8'h00;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA;
  logic [6:0] SINK_ON;
  logic [1:0] FADE_PROFILE;
  int         err_count;
  int         check_count;
  int         last_on;
  int         last_off;
  int         model[4];
  int         msk[4]  = '{3, 127, 255, 255};
  int         ont[4]  = '{1, 3, 4, 6};
  logic [1:0] prof[4] = '{PROFILE_LINEAR, PROFILE_LINEAR, PROFILE_CUBIC_A, PROFILE_CUBIC_B};
  led_sink_blink_fade_control #(.TICK_CYCLES(TK)) DUT (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RDATA(RDATA), .SINK_ON(SINK_ON), .FADE_PROFILE(FADE_PROFILE));
  sink_led_load LOAD (.CLOCK(CLOCK), .lit(SINK_ON[4]), .last_on(last_on), .last_off(last_off));
  initial forever #12.5 CLOCK = ~CLOCK;
  task automatic wr(input int a, input int d);
    ADDR = 8'(a);
    WDATA = 8'(d);
    WR = 1;
    @(negedge CLOCK);
    WR = 0;
    if (a >= 26 && a <= 29) model[a-26] = d & msk[a-26];
    @(negedge CLOCK);
  endtask
  task automatic rd(input int a);
    int e;
    e = (a >= 26 && a <= 29) ? model[a-26] : 0;
    ADDR = 8'(a);
    @(negedge CLOCK);
    `CHK(RDATA, 8'(e))
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    int a;
    void'($urandom(32'h90FEEEEB));
    repeat (4) @(negedge CLOCK);
    RST = 0;
    for (int i = 25; i < 31; i++) rd(i);
    repeat (24) begin
      a = 25 + $urandom % 6;
      wr(a, $urandom % 256);
      rd(a);
    end
    for (int i = 27; i < 30; i++) wr(i, 0);
    foreach (prof[l]) begin
      wr(26, l);
      @(negedge CLOCK);
      `CHK(FADE_PROFILE, prof[l])
    end
    for (int i = 0; i < 8; i++) begin
      wr(27, i < 7 ? 1 << i : 8'h7F);
      repeat (30) begin
        @(negedge CLOCK);
        `CHK(SINK_ON, 7'(i < 7 ? 1 << i : 8'h7F))
      end
    end
    for (int on = 0; on < 4; on++) begin
      for (int off = 1; off < 4; off++) begin
        wr(27, 0);
        wr(28, on * 64 + off * 5);
        wr(29, off * 85);
        // All seven go in one write so sinks one..six blink in phase while sink seven stays on.
        wr(27, 8'h7F);
        `CHK(SINK_ON[4], 1'b1)
        repeat ((ont[on] + 3 * off) * TK * 3) begin
          @(negedge CLOCK);
          `CHK(SINK_ON[5:0], {6{SINK_ON[4]}})
          `CHK(SINK_ON[6], 1'b1)
        end
        `CHK(last_on, ont[on] * TK)
        `CHK(last_off, off * 3 * TK)
      end
    end
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    err_count++;
    wrap_up();
  end
endmodule
